//--- design/pse_defines.vh
// Purpose: Constants shared by the transceiver status and error counter block
// Assumes: Included by bare name from every design file except the two-flop synchroniser
// Notes: Byte address of a register is four times its index
`ifndef PSE_DEFINES_VH
`define PSE_DEFINES_VH

// Register indices
`define PSE_IDX_FALSE_CARRIER 8'h14
`define PSE_IDX_SYMBOL_ERROR 8'h15
`define PSE_IDX_SUMMARY 8'h10
`define PSE_IDX_IRQ_STATUS 8'h1a
`define PSE_IDX_IRQ_MASK 8'h1b

// Byte addresses
`define PSE_ADDR_FALSE_CARRIER 8'h50
`define PSE_ADDR_SYMBOL_ERROR 8'h54
`define PSE_ADDR_SUMMARY 8'h40
`define PSE_ADDR_IRQ_STATUS 8'h68
`define PSE_ADDR_IRQ_MASK 8'h6c

// Summary field positions
`define PSE_SUM_LINK 0
`define PSE_SUM_SPEED10 1
`define PSE_SUM_DUPLEX 2
`define PSE_SUM_LOOPBACK 3
`define PSE_SUM_ANEG_DONE 4
`define PSE_SUM_FC_LATCH 11
`define PSE_SUM_RXERR_LATCH 13

// Interrupt field positions
`define PSE_IRQ_FALSE_CARRIER 0
`define PSE_IRQ_SYMBOL_ERROR 1
`define PSE_IRQ_LINK_CHANGE 2
`define PSE_IRQ_WIDTH 3

// Counter width and saturation value
`define PSE_CNT_WIDTH 8
`define PSE_CNT_MAX 8'hff

// Reset values
`define PSE_RST_CNT 8'h00
`define PSE_RST_IRQ 3'h0
`define PSE_RST_DATA 32'h00000000

`endif

//--- design/pse_sync2.v
// Purpose: Two-flop level synchroniser, one stage pair per bit
// Assumes: Inputs are slow levels from outside the clock domain
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module pse_sync2 #(
   parameter WIDTH = 5
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Levels
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : gBit
         reg stage1;
         reg stage2;
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end else begin
               stage1 <= asyncIn[i];
               stage2 <= stage1;
            end
         end
         assign syncOut[i] = stage2;
      end
   endgenerate

endmodule

//--- design/pse_sat_counter.v
// Purpose: Saturating event counter with clear on read
// Assumes: inc and clr are one-cycle pulses on clk_sys
// Notes: An event coinciding with the clear is counted after it
`include "pse_defines.vh"
`timescale 1ns/1ps
module pse_sat_counter (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Control
   input wire inc,
   input wire clr,
   // Value
   output reg [`PSE_CNT_WIDTH-1:0] count
);

   reg [`PSE_CNT_WIDTH-1:0] next_count;

   always @* begin
      next_count = count;
      if (clr) begin
         // Clear first, then count the coinciding event
         next_count = inc ? {{(`PSE_CNT_WIDTH-1){1'b0}}, 1'b1} : `PSE_RST_CNT;
      end else if (inc && (count != `PSE_CNT_MAX)) begin
         next_count = count + {{(`PSE_CNT_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count <= `PSE_RST_CNT;
      end else begin
         count <= next_count;
      end
   end

endmodule

//--- design/pse_status_counters.v
// Purpose: Status summary, false-carrier and symbol-error counters on AHB-Lite
// Assumes: Event inputs come from receive logic on clk_sys; status levels are
//          asynchronous and are synchronised here
// Notes: Zero wait states; read data is captured in the address phase
//
// Contract
// - Summary bit 4 shows one once auto-negotiation finished, else zero.
// - Summary bit 3 shows one while loopback is active.
// - Summary bit 2 shows resolved duplex, one full, zero half.
// - Summary bit 1 shows resolved speed, one for 10, zero for 100.
// - Summary bit 0 mirrors link status; reading summary does not clear it.
// - False-carrier count is 8 bits, increments per event, sticks at ff.
// - Reading false-carrier count returns it then clears; writes ignored.
// - Symbol-error count increments on error during valid carrier.
// - Symbol-error count advances at most once per carrier event.
// - No symbol-error count for a carrier event with collision.
// - Symbol-error count sticks at maximum; read returns then clears.
// - Counter bits 15:8 read zero; writes there are ignored.
// - Summary bit 13 latches any receive error; cleared by error count read.
// - Summary bit 11 latches false carrier; cleared by false-carrier read.
`include "pse_defines.vh"
`timescale 1ns/1ps
module pse_status_counters (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   // Asynchronous status levels
   input wire anegDone,
   input wire loopbackOn,
   input wire fullDuplex,
   input wire speed10,
   input wire linkUp,
   // Receive events on clk_sys
   input wire falseCarrierEvt,
   input wire rxErrorEvt,
   input wire carrierValid,
   input wire collision,
   // Interrupt
   output reg irq
);

   localparam NSTAT = 5;

   // Synchronised status levels
   wire [NSTAT-1:0] statusRaw;
   wire [NSTAT-1:0] statusSync;
   wire linkSync;

   // Bus decode
   wire addrPhase;
   wire rdReq;
   wire wrReq;
   wire [7:0] reqAddr;
   wire rdFalseCarrier;
   wire rdSymbolError;
   reg wrPend;
   reg [7:0] wrAddr;

   // Counters and latches
   wire [`PSE_CNT_WIDTH-1:0] falseCarrierTally;
   wire [`PSE_CNT_WIDTH-1:0] symbolErrorTally;
   reg fcLatch;
   reg rxErrLatch;
   reg next_fcLatch;
   reg next_rxErrLatch;

   // Carrier event tracking
   reg carrierPrev;
   reg errSeen;
   reg collSeen;
   reg next_errSeen;
   reg next_collSeen;
   wire carrierEnd;
   wire symbolErrCount;

   // Interrupt registers
   reg linkPrev;
   reg [`PSE_IRQ_WIDTH-1:0] irqStatus;
   reg [`PSE_IRQ_WIDTH-1:0] irqMask;
   reg [`PSE_IRQ_WIDTH-1:0] next_irqStatus;
   wire [`PSE_IRQ_WIDTH-1:0] irqEvents;
   wire [`PSE_IRQ_WIDTH-1:0] irqClear;

   // Read data
   reg [31:0] next_rdata;
   wire [15:0] summaryWord;

   assign statusRaw = {anegDone, loopbackOn, fullDuplex, speed10, linkUp};

   pse_sync2 #(
      .WIDTH(NSTAT)
   ) uSync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .asyncIn(statusRaw),
      .syncOut(statusSync)
   );

   assign linkSync = statusSync[0];

   // Address phase accepted when selected with an active transfer and the bus is ready
   assign addrPhase = hsel && htrans[1] && hready;
   assign rdReq = addrPhase && !hwrite;
   assign wrReq = addrPhase && hwrite;
   assign reqAddr = haddr[7:0];

   // Clearing reads act at the address phase edge, value captured at that edge
   assign rdFalseCarrier = rdReq && (reqAddr == `PSE_ADDR_FALSE_CARRIER);
   assign rdSymbolError = rdReq && (reqAddr == `PSE_ADDR_SYMBOL_ERROR);

   // Write address held over into the data phase
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else begin
         wrPend <= wrReq;
         if (wrReq) begin
            wrAddr <= reqAddr;
         end
      end
   end

   // Carrier events: one count at the end of a clean carrier with an error
   assign carrierEnd = carrierPrev && !carrierValid;
   assign symbolErrCount = carrierEnd && errSeen && !collSeen;

   always @* begin
      next_errSeen = errSeen;
      next_collSeen = collSeen;
      if (carrierValid && !carrierPrev) begin
         // New carrier event starts clean
         next_errSeen = rxErrorEvt;
         next_collSeen = collision;
      end else if (carrierValid) begin
         if (rxErrorEvt) begin
            next_errSeen = 1'b1;
         end
         if (collision) begin
            next_collSeen = 1'b1;
         end
      end else begin
         next_errSeen = 1'b0;
         next_collSeen = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         carrierPrev <= 1'b0;
         errSeen <= 1'b0;
         collSeen <= 1'b0;
      end else begin
         carrierPrev <= carrierValid;
         errSeen <= next_errSeen;
         collSeen <= next_collSeen;
      end
   end

   // Counters saturate and clear on read, events after the clear survive
   pse_sat_counter uFalseCarrier (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .inc(falseCarrierEvt),
      .clr(rdFalseCarrier),
      .count(falseCarrierTally)
   );

   pse_sat_counter uSymbolError (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .inc(symbolErrCount),
      .clr(rdSymbolError),
      .count(symbolErrorTally)
   );

   // Latches: a set in the clearing cycle wins
   always @* begin
      next_fcLatch = fcLatch;
      next_rxErrLatch = rxErrLatch;
      if (rdFalseCarrier) begin
         next_fcLatch = 1'b0;
      end
      if (falseCarrierEvt) begin
         next_fcLatch = 1'b1;
      end
      if (rdSymbolError) begin
         next_rxErrLatch = 1'b0;
      end
      if (rxErrorEvt) begin
         // Any receive error, even one the counter will not take
         next_rxErrLatch = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fcLatch <= 1'b0;
         rxErrLatch <= 1'b0;
      end else begin
         fcLatch <= next_fcLatch;
         rxErrLatch <= next_rxErrLatch;
      end
   end

   // Summary word; reading it clears nothing
   assign summaryWord = {
      2'b00,
      rxErrLatch,
      1'b0,
      fcLatch,
      6'b000000,
      statusSync[4],
      statusSync[3],
      statusSync[2],
      statusSync[1],
      linkSync
   };

   // Interrupt sources
   assign irqEvents[`PSE_IRQ_FALSE_CARRIER] = falseCarrierEvt;
   assign irqEvents[`PSE_IRQ_SYMBOL_ERROR] = symbolErrCount;
   assign irqEvents[`PSE_IRQ_LINK_CHANGE] = linkSync ^ linkPrev;

   // Write-one-to-clear in the data phase
   assign irqClear = (wrPend && (wrAddr == `PSE_ADDR_IRQ_STATUS)) ?
      hwdata[`PSE_IRQ_WIDTH-1:0] : `PSE_RST_IRQ;

   always @* begin
      // Set beats clear so no event is lost
      next_irqStatus = (irqStatus & ~irqClear) | irqEvents;
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         linkPrev <= 1'b0;
         irqStatus <= `PSE_RST_IRQ;
         irqMask <= `PSE_RST_IRQ;
         irq <= 1'b0;
      end else begin
         linkPrev <= linkSync;
         irqStatus <= next_irqStatus;
         if (wrPend && (wrAddr == `PSE_ADDR_IRQ_MASK)) begin
            irqMask <= hwdata[`PSE_IRQ_WIDTH-1:0];
         end
         // Registered output, one cycle behind the status bits
         irq <= |(irqStatus & irqMask);
      end
   end

   // Read mux; counters are read-only so their writes fall through
   always @* begin
      next_rdata = `PSE_RST_DATA;
      case (reqAddr)
         `PSE_ADDR_FALSE_CARRIER: begin
            next_rdata = {24'h000000, falseCarrierTally};
         end
         `PSE_ADDR_SYMBOL_ERROR: begin
            next_rdata = {24'h000000, symbolErrorTally};
         end
         `PSE_ADDR_SUMMARY: begin
            next_rdata = {16'h0000, summaryWord};
         end
         `PSE_ADDR_IRQ_STATUS: begin
            next_rdata = {29'h0, irqStatus};
         end
         `PSE_ADDR_IRQ_MASK: begin
            next_rdata = {29'h0, irqMask};
         end
         default: begin
            next_rdata = `PSE_RST_DATA;
         end
      endcase
   end

   // Bus outputs from flops; never stalls and always OKAY
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= `PSE_RST_DATA;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rdReq) begin
            hrdata <= next_rdata;
         end else begin
            hrdata <= `PSE_RST_DATA;
         end
      end
   end

endmodule

//--- verification/pse_status_counters_sva.sv
// Purpose: Port checks of the status and counter block
// Assumes: Zero wait states, read data one cycle after the address edge
// Notes: Summary checks wait for the two-flop status synchroniser
`timescale 1ns/1ps
module pse_status_counters_sva (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire irq,
   // Status and events
   input wire anegDone,
   input wire loopbackOn,
   input wire fullDuplex,
   input wire speed10,
   input wire linkUp,
   input wire falseCarrierEvt,
   input wire carrierValid
);
   wire req = hsel && htrans[1] && hready;
   wire rd = req && !hwrite;
   wire rdFc = rd && haddr[7:0] == 8'h50;
   wire rdSe = rd && haddr[7:0] == 8'h54;
   wire rdSum = rd && haddr[7:0] == 8'h40;
   wire wrMask = req && hwrite && haddr[7:0] == 8'h6c;
   wire [4:0] st = {anegDone, loopbackOn, fullDuplex, speed10, linkUp};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_SUM_HI: assert property (rdSum && $past(rst_b, 2) && st == $past(st) &&
      st == $past(st, 2) |=> hrdata[4:3] == $past(st[4:3]))
      else $error("summary negotiation or loopback wrong");
   AST_SUM_LO: assert property (rdSum && $past(rst_b, 2) && st == $past(st) &&
      st == $past(st, 2) |=> hrdata[2:0] == $past(st[2:0]))
      else $error("summary duplex, speed or link wrong");
   AST_FC_CLEAR: assert property (rdFc && !falseCarrierEvt ##1 rdFc |=> hrdata[7:0] == 8'h00)
      else $error("false carrier tally not cleared by read");
   AST_FC_COINCIDE: assert property (rdFc && falseCarrierEvt ##1 rdFc |=> hrdata[7:0] == 8'h01)
      else $error("event during clearing read lost");
   AST_SE_CLEAR: assert property (rdSe && !carrierValid && !$past(carrierValid) ##1 rdSe
      |=> hrdata[7:0] == 8'h00)
      else $error("symbol error tally not cleared by read");
   AST_CNT_UPPER: assert property (rdFc || rdSe |=> hrdata[31:8] == 24'h0)
      else $error("counter upper bits not zero");
   AST_IRQ_MASK: assert property (wrMask ##1 hwdata[2:0] == 3'h0 |=> ##1 !irq)
      else $error("interrupt high with all sources masked");
endmodule

bind pse_status_counters pse_status_counters_sva i_sva (
   .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .irq(irq), .anegDone(anegDone),
   .loopbackOn(loopbackOn), .fullDuplex(fullDuplex), .speed10(speed10),
   .linkUp(linkUp), .falseCarrierEvt(falseCarrierEvt), .carrierValid(carrierValid)
);

//--- verification/pse_ahb_master.sv
// Purpose: Management side AHB-Lite master
// Assumes: Single word transfers, signals change right after a rising edge
// Notes: rd2 holds one address phase over two edges for pipelined reads
`timescale 1ns/1ps
module pse_ahb_master (
   // Clock
   input wire clk_sys,
   // AHB-Lite master
   output logic hsel = 1'b0,
   output logic [31:0] haddr = 32'h0,
   output logic [1:0] htrans = 2'h0,
   output logic hwrite = 1'b0,
   output logic [2:0] hsize = 3'h2,
   output logic [31:0] hwdata = 32'h0,
   input wire hready,
   input wire [31:0] hrdata
);
   task automatic addr(input logic w, input logic [7:0] a);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
   endtask
   task automatic rdy;
      do @(posedge clk_sys); while (hready !== 1'b1);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      addr(w, a);
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      q = hrdata;
      // Inverted once released so stale data never looks live
      hwdata <= ~d;
   endtask
   task automatic rd2(input logic [7:0] a, output logic [31:0] q1, q2);
      addr(1'b0, a);
      rdy;
      rdy;
      q1 = hrdata;
      hsel <= 1'b0;
      htrans <= 2'h0;
      rdy;
      q2 = hrdata;
   endtask
endmodule

//--- verification/test_phy_status_error_counters.sv
// Purpose: Self-checking bench of the status and counter block
// Assumes: Events and status levels driven on the rising edge
// Notes: Random stimulus from a fixed-seed shift register
`timescale 1ns/1ps
module test_phy_status_error_counters;
   logic clk_sys, rst_b, fcEvt, rxErr, carrier, coll;
   logic [4:0] st;
   wire hsel, hwrite, hreadyout, hresp, irq;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   logic [31:0] q, q2;
   logic [15:0] rnd;
   logic [7:0] regs[6] = '{8'h50, 8'h54, 8'h40, 8'h68, 8'h6c, 8'h7c};
   int errors, checks_done, n;
   pse_status_counters i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .anegDone(st[4]), .loopbackOn(st[3]), .fullDuplex(st[2]), .speed10(st[1]),
      .linkUp(st[0]), .falseCarrierEvt(fcEvt), .rxErrorEvt(rxErr),
      .carrierValid(carrier), .collision(coll), .irq(irq));
   pse_ahb_master i_mst (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] sat(input int c);
      return (c > 255) ? 32'hff : 32'(c);
   endfunction
   function automatic logic [31:0] sum(input logic fc, input logic rx);
      return {18'h0, rx, 1'b0, fc, 6'h0, st};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      i_mst.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_mst.xfer(1'b1, a, d, q);
   endtask
   task automatic fcRun(input int cycles, input logic all);
      repeat (cycles) begin
         @(posedge clk_sys);
         rnd = lfsr(rnd);
         fcEvt <= rnd[0] | all;
         n += rnd[0] | all;
      end
      @(posedge clk_sys);
      fcEvt <= 1'b0;
   endtask
   task automatic car(input int len, input logic [7:0] em, input logic c);
      for (int i = 0; i < len; i++) begin
         @(posedge clk_sys);
         {carrier, rxErr, coll} <= {1'b1, em[i], c};
      end
      @(posedge clk_sys);
      {carrier, rxErr, coll} <= 3'h0;
      @(posedge clk_sys);
   endtask
   task automatic test_done;
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      test_done;
   end
   initial begin
      {st, fcEvt, rxErr, carrier, coll, rst_b} = 10'h0;
      rnd = 16'd28920;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      foreach (regs[i]) rc(regs[i], 32'h0);
      repeat (6) begin
         rnd = lfsr(rnd);
         @(posedge clk_sys);
         st <= rnd[4:0];
         repeat (3) @(posedge clk_sys);
         rc(8'h40, sum(1'b0, 1'b0));
         rc(8'h40, sum(1'b0, 1'b0));
      end
      n = 0;
      fcRun(40, 1'b0);
      wr(8'h50, 32'hffffffff);
      rc(8'h40, sum(n > 0, 1'b0));
      rc(8'h50, sat(n));
      rc(8'h40, sum(1'b0, 1'b0));
      n = 0;
      fcRun(300, 1'b1);
      rc(8'h50, sat(n));
      n = 0;
      fcRun(3, 1'b1);
      fork
         i_mst.rd2(8'h50, q, q2);
         begin
            @(posedge clk_sys);
            fcEvt <= 1'b1;
            @(posedge clk_sys);
            fcEvt <= 1'b0;
         end
      join
      chk(q, sat(n));
      chk(q2, 32'h1);
      i_mst.rd2(8'h50, q, q2);
      chk(q2, 32'h0);
      car(4, 8'h00, 1'b0);
      car(5, 8'h1a, 1'b0);
      car(3, 8'h05, 1'b1);
      car(2, 8'h02, 1'b0);
      rc(8'h40, sum(1'b0, 1'b1));
      rc(8'h54, 32'h2);
      rc(8'h40, sum(1'b0, 1'b0));
      car(0, 8'h00, 1'b0);
      repeat (260) car(1, 8'h01, 1'b0);
      i_mst.rd2(8'h54, q, q2);
      chk(q, 32'hff);
      chk(q2, 32'h0);
      wr(8'h68, 32'h7);
      wr(8'h6c, 32'h1);
      rc(8'h6c, 32'h1);
      fcRun(1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      rc(8'h68, 32'h1);
      wr(8'h68, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wr(8'h6c, 32'h0);
      fcRun(1, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      rc(8'h68, 32'h1);
      test_done;
   end
endmodule
